//--- msnp_pkg.sv
// Shared constants and carriers for the multi-speed and window-output logic.
// Assumes one 200 MHz clock domain and parameter writes keyed by attribute number.
package msnp_pkg;

    // ----------------------------------------------------------------
    // Widths and sizes
    // ----------------------------------------------------------------
    localparam int POS_W   = 32;   // Encoder steps, two's complement
    localparam int SPD_W   = 16;   // Units of 1,000 steps/min
    localparam int STAGES  = 16;
    localparam int IDX_W   = 4;
    localparam int CNT_W   = 5;

    // ----------------------------------------------------------------
    // Parameter attribute numbers (register offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] ATTR_STAGE_COUNT   = 8'h6f;  // 111
    localparam logic [7:0] ATTR_INIT_SPEED    = 8'h70;  // 112
    localparam logic [7:0] ATTR_POS_FIRST     = 8'h71;  // 113
    localparam logic [7:0] ATTR_POS_LAST      = 8'h80;  // 128
    localparam logic [7:0] ATTR_SPD_FIRST     = 8'h81;  // 129
    localparam logic [7:0] ATTR_SPD_LAST      = 8'h90;  // 144
    localparam logic [7:0] ATTR_WIN_REF       = 8'ha0;  // 160
    localparam logic [7:0] ATTR_WIN_POL       = 8'ha1;  // 161
    localparam logic [7:0] ATTR_WIN_A_LO      = 8'ha2;  // 162
    localparam logic [7:0] ATTR_WIN_A_HI      = 8'ha3;  // 163
    localparam logic [7:0] ATTR_WIN_B_LO      = 8'ha4;  // 164
    localparam logic [7:0] ATTR_WIN_B_HI      = 8'ha5;  // 165

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int POL_A_BIT = 0;
    localparam int POL_B_BIT = 1;
    localparam logic [CNT_W-1:0] RST_STAGE_COUNT = 5'h00;
    localparam logic [SPD_W-1:0] RST_INIT_SPEED  = 16'h0000;
    localparam logic             RST_WIN_REF     = 1'b0;      // Absolute
    localparam logic [15:0]      RST_WIN_POL     = 16'h0000;
    localparam logic [POS_W-1:0] RST_LIMIT       = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic             wr;     // One-cycle write strobe
        logic [7:0]       attr;   // Attribute number
        logic [POS_W-1:0] data;
    } msnp_param_t;

    typedef struct packed {
        logic             wr;
        logic             sel_speed;  // 1: speed array, 0: position array
        logic [IDX_W-1:0] idx;
        logic [POS_W-1:0] data;
    } msnp_tbl_wr_t;

    typedef struct packed {
        logic [POS_W-1:0] pos;
        logic [SPD_W-1:0] speed;
    } msnp_entry_t;

    typedef struct packed {
        logic win_a;
        logic win_b;
    } msnp_win_t;

    typedef enum logic {MSNP_IDLE, MSNP_RUN} msnp_mode_t;

endpackage

//--- msnp_table.sv
// Sixteen-entry switch-position and speed table with a registered read port.
// Assumes writes and reads on the same clock; read data lags the address by one cycle.
`timescale 1ns/1ps
module msnp_table (
    input  wire logic                       clk,
    input  wire msnp_pkg::msnp_tbl_wr_t     wr,
    input  wire logic [msnp_pkg::IDX_W-1:0] rd_idx,
    output msnp_pkg::msnp_entry_t           rd_data
);
    logic [msnp_pkg::POS_W-1:0] pos_mem [msnp_pkg::STAGES];
    logic [msnp_pkg::SPD_W-1:0] spd_mem [msnp_pkg::STAGES];

    // ----------------------------------------------------------------
    // Write and registered read
    // ----------------------------------------------------------------
    // No reset on the arrays: contents are only meaningful once written
    always_ff @(posedge clk) begin
        if (wr.wr && !wr.sel_speed) begin
            pos_mem[wr.idx] <= wr.data;
        end
        if (wr.wr && wr.sel_speed) begin
            spd_mem[wr.idx] <= wr.data[msnp_pkg::SPD_W-1:0];
        end
        rd_data.pos   <= pos_mem[rd_idx];
        rd_data.speed <= spd_mem[rd_idx];
    end
endmodule

//--- msnp_core.sv
// Multi-speed stage selector and two position-window outputs.
// Assumes present position comes from the servo loop on the same clock.
`timescale 1ns/1ps
module msnp_core (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire msnp_pkg::msnp_param_t        param,
    input  wire logic                         move_start,
    input  wire logic                         move_active,
    input  wire logic [msnp_pkg::POS_W-1:0]   present_pos,
    output logic [msnp_pkg::SPD_W-1:0]        cmd_speed,
    output logic [msnp_pkg::CNT_W-1:0]        stage,
    output msnp_pkg::msnp_win_t               win_out,
    output logic [15:0]                       window_output_polarity
);
    typedef struct packed {
        msnp_pkg::msnp_mode_t        mode;
        logic [msnp_pkg::CNT_W-1:0]  stage_count;
        logic [msnp_pkg::SPD_W-1:0]  stage_initial_speed;
        logic                        window_reference_select;
        logic [15:0]                 window_output_polarity;
        logic [msnp_pkg::POS_W-1:0]  window_a_low_limit;
        logic [msnp_pkg::POS_W-1:0]  window_a_high_limit;
        logic [msnp_pkg::POS_W-1:0]  window_b_low_limit;
        logic [msnp_pkg::POS_W-1:0]  window_b_high_limit;
        logic [msnp_pkg::POS_W-1:0]  start_pos;
        logic [msnp_pkg::CNT_W-1:0]  stage;
        logic                        settle;
        logic [msnp_pkg::SPD_W-1:0]  cmd_speed;
        msnp_pkg::msnp_win_t         win;
    } msnp_state_t;

    // Whole register image in one struct; table arrays live in msnp_table
    msnp_state_t            st;
    msnp_state_t            next_st;
    msnp_pkg::msnp_tbl_wr_t tbl_wr;
    msnp_pkg::msnp_entry_t  entry;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Inclusive signed window test, optionally offset by the start point
    // Relative limits wrap modulo 2^32; there is no overflow detection
    function automatic logic in_window(input logic [msnp_pkg::POS_W-1:0] pos,
                                       input logic [msnp_pkg::POS_W-1:0] lo,
                                       input logic [msnp_pkg::POS_W-1:0] hi,
                                       input logic                        rel,
                                       input logic [msnp_pkg::POS_W-1:0] base);
        logic [msnp_pkg::POS_W-1:0] lo_eff;
        logic [msnp_pkg::POS_W-1:0] hi_eff;
        lo_eff = rel ? lo + base : lo;
        hi_eff = rel ? hi + base : hi;
        return ($signed(pos) >= $signed(lo_eff)) && ($signed(pos) <= $signed(hi_eff));
    endfunction

    // Magnitude of travel, so moves in either direction reach the stages
    function automatic logic [msnp_pkg::POS_W-1:0] magnitude(
        input logic [msnp_pkg::POS_W-1:0] v);
        return v[msnp_pkg::POS_W-1] ? msnp_pkg::POS_W'(-v) : v;
    endfunction

    // Attribute range test shared by the two table decodes
    function automatic logic attr_in_range(input logic [7:0] attr,
                                           input logic [7:0] first,
                                           input logic [7:0] last);
        return (attr >= first) && (attr <= last);
    endfunction

    // Output level: resting polarity, flipped inside the window during a move
    // Idle windows rest, so a stale position cannot pulse an output
    function automatic logic window_level(input logic                        pol,
                                          input logic                        run,
                                          input logic [msnp_pkg::POS_W-1:0] pos,
                                          input logic [msnp_pkg::POS_W-1:0] lo,
                                          input logic [msnp_pkg::POS_W-1:0] hi,
                                          input logic                        rel,
                                          input logic [msnp_pkg::POS_W-1:0] base);
        return pol ^ (run && in_window(pos, lo, hi, rel, base));
    endfunction

    // ----------------------------------------------------------------
    // Table write decode and read address
    // ----------------------------------------------------------------
    logic                       wr_pos;
    logic                       wr_spd;
    logic [7:0]                 wr_off;
    logic [msnp_pkg::POS_W-1:0] travel;

    assign wr_pos = param.wr && attr_in_range(param.attr, msnp_pkg::ATTR_POS_FIRST,
                                              msnp_pkg::ATTR_POS_LAST);
    assign wr_spd = param.wr && attr_in_range(param.attr, msnp_pkg::ATTR_SPD_FIRST,
                                              msnp_pkg::ATTR_SPD_LAST);
    assign wr_off = wr_spd ? param.attr - msnp_pkg::ATTR_SPD_FIRST
                           : param.attr - msnp_pkg::ATTR_POS_FIRST;
    assign tbl_wr.wr        = wr_pos || wr_spd;
    assign tbl_wr.sel_speed = wr_spd;
    assign tbl_wr.idx       = wr_off[msnp_pkg::IDX_W-1:0];
    assign tbl_wr.data      = param.data;
    assign travel           = magnitude(present_pos - st.start_pos);

    // Entry k holds switch position k+1 and its paired speed
    msnp_table u_table (
        .clk     (clk),
        .wr      (tbl_wr),
        .rd_idx  (st.stage[msnp_pkg::IDX_W-1:0]),
        .rd_data (entry)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Parameter writes
        if (param.wr) begin
            case (param.attr)
                msnp_pkg::ATTR_STAGE_COUNT: begin
                    // Counts above the table size clamp to the table size
                    next_st.stage_count = (param.data > 32'(msnp_pkg::STAGES))
                        ? msnp_pkg::CNT_W'(msnp_pkg::STAGES)
                        : param.data[msnp_pkg::CNT_W-1:0];
                end
                msnp_pkg::ATTR_INIT_SPEED:
                    next_st.stage_initial_speed = param.data[msnp_pkg::SPD_W-1:0];
                msnp_pkg::ATTR_WIN_REF:  next_st.window_reference_select = param.data[0];
                msnp_pkg::ATTR_WIN_POL:  next_st.window_output_polarity = param.data[15:0];
                msnp_pkg::ATTR_WIN_A_LO: next_st.window_a_low_limit  = param.data;
                msnp_pkg::ATTR_WIN_A_HI: next_st.window_a_high_limit = param.data;
                msnp_pkg::ATTR_WIN_B_LO: next_st.window_b_low_limit  = param.data;
                msnp_pkg::ATTR_WIN_B_HI: next_st.window_b_high_limit = param.data;
                default: ;
            endcase
        end

        // Stage sequencing
        next_st.settle = 1'b0;
        case (st.mode)
            msnp_pkg::MSNP_IDLE: begin
                next_st.cmd_speed = '0;
            end
            msnp_pkg::MSNP_RUN: begin
                // Read data lags a stage change by one cycle, so skip that cycle
                // Limitation: one stage per two cycles, so two switch points
                // crossed at once are taken on successive checks
                if (!st.settle && (st.stage < st.stage_count)
                        && (travel >= entry.pos)) begin
                    next_st.cmd_speed = entry.speed;
                    next_st.stage     = st.stage + 1'b1;
                    next_st.settle    = 1'b1;
                end
                if (!move_active) begin
                    next_st.mode = msnp_pkg::MSNP_IDLE;
                end
            end
            default: next_st.mode = msnp_pkg::MSNP_IDLE;
        endcase

        // Move start latches the reference point; takes priority over sequencing
        // A restart mid-move drops the old stage and begins again at stage 0
        if (move_start) begin
            next_st.mode      = msnp_pkg::MSNP_RUN;
            next_st.start_pos = present_pos;
            next_st.stage     = '0;
            next_st.settle    = 1'b1;
            next_st.cmd_speed = st.stage_initial_speed;
        end

        // Window outputs: invert from resting level only inside a move
        next_st.win.win_a = window_level(
            st.window_output_polarity[msnp_pkg::POL_A_BIT],
            st.mode == msnp_pkg::MSNP_RUN,
            present_pos, st.window_a_low_limit, st.window_a_high_limit,
            st.window_reference_select, st.start_pos);
        next_st.win.win_b = window_level(
            st.window_output_polarity[msnp_pkg::POL_B_BIT],
            st.mode == msnp_pkg::MSNP_RUN,
            present_pos, st.window_b_low_limit, st.window_b_high_limit,
            st.window_reference_select, st.start_pos);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Table arrays are not reset; load every used entry before a move
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st                         <= '0;
            st.mode                    <= msnp_pkg::MSNP_IDLE;
            st.stage_count             <= msnp_pkg::RST_STAGE_COUNT;
            st.stage_initial_speed     <= msnp_pkg::RST_INIT_SPEED;
            st.window_reference_select <= msnp_pkg::RST_WIN_REF;
            st.window_output_polarity  <= msnp_pkg::RST_WIN_POL;
            st.window_a_low_limit      <= msnp_pkg::RST_LIMIT;
            st.window_a_high_limit     <= msnp_pkg::RST_LIMIT;
            st.window_b_low_limit      <= msnp_pkg::RST_LIMIT;
            st.window_b_high_limit     <= msnp_pkg::RST_LIMIT;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Straight from the state register, so every data output is a flop
    assign cmd_speed              = st.cmd_speed;
    assign stage                  = st.stage;
    assign win_out                = st.win;
    assign window_output_polarity = st.window_output_polarity;
endmodule

//--- msnp_core_sva.sv
// Assertions on the stage, speed and window outputs of msnp_core.
// Assumes one clock and a synchronous reset held at least two cycles.
`timescale 1ns/1ps
module msnp_core_sva (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire msnp_pkg::msnp_param_t      param,
    input wire logic                       move_start,
    input wire logic                       move_active,
    input wire logic [msnp_pkg::POS_W-1:0] present_pos,
    input wire logic [msnp_pkg::SPD_W-1:0] cmd_speed,
    input wire logic [msnp_pkg::CNT_W-1:0] stage,
    input wire msnp_pkg::msnp_win_t        win_out,
    input wire logic [15:0]                window_output_polarity
);
    // ----
    // Shadow of written settings
    // ----
    logic [31:0] a_lo, a_hi, b_lo, b_hi, start_q;
    logic [15:0] init_q, pol_q, pol_data;
    logic [4:0]  cnt_q;
    logic        ref_q, run_q, exp_a, exp_b;
    wire  [31:0] off = ref_q ? start_q : 32'h0000_0000;

    // Mirrors the design registers, so a write lands one cycle later
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {a_lo, a_hi, b_lo, b_hi, start_q, init_q, pol_q, cnt_q, ref_q, run_q} <= '0;
        end else begin
            run_q <= move_start | (run_q & move_active);
            if (move_start) begin
                start_q <= present_pos;
            end
            if (param.wr) begin
                case (param.attr)
                    msnp_pkg::ATTR_STAGE_COUNT: cnt_q <= (param.data > 32'h10) ? 5'h10 : param.data[4:0];
                    msnp_pkg::ATTR_INIT_SPEED:  init_q <= param.data[15:0];
                    msnp_pkg::ATTR_WIN_REF:     ref_q <= param.data[0];
                    msnp_pkg::ATTR_WIN_POL:     pol_q <= param.data[15:0];
                    msnp_pkg::ATTR_WIN_A_LO:    a_lo <= param.data;
                    msnp_pkg::ATTR_WIN_A_HI:    a_hi <= param.data;
                    msnp_pkg::ATTR_WIN_B_LO:    b_lo <= param.data;
                    msnp_pkg::ATTR_WIN_B_HI:    b_hi <= param.data;
                    default: ;
                endcase
            end
        end
    end

    // Expected levels: polarity, flipped inside the inclusive span while running
    always_comb begin
        pol_data = param.data[15:0];
        exp_a = pol_q[0] ^ (run_q & ($signed(present_pos) >= $signed(a_lo + off))
                & ($signed(present_pos) <= $signed(a_hi + off)));
        exp_b = pol_q[1] ^ (run_q & ($signed(present_pos) >= $signed(b_lo + off))
                & ($signed(present_pos) <= $signed(b_hi + off)));
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_idle3;
        (!move_active && !move_start) [*3];
    endsequence
    sequence s_advance;
        stage == $past(stage) + 5'h01;
    endsequence

    start_speed_a:
        assert property (move_start |=> cmd_speed == $past(init_q) && stage == 5'h00)
        else $error("start speed or stage wrong");
    idle_speed_a:
        assert property (s_idle3 |=> cmd_speed == 16'h0000)
        else $error("speed not zero while idle");
    pol_write_a:
        assert property (param.wr && param.attr == msnp_pkg::ATTR_WIN_POL
            |=> window_output_polarity == $past(pol_data))
        else $error("polarity write not seen");
    stage_step_a:
        assert property (stage != $past(stage) && !$past(move_start) |-> s_advance)
        else $error("stage moved by other than one");
    advance_gap_a:
        assert property (s_advance |=> $stable(stage) || stage == 5'h00)
        else $error("stage advanced twice in a row");
    stage_limit_a:
        assert property (stage <= cnt_q)
        else $error("stage beyond switch count");
    win_a_level_a:
        assert property (win_out.win_a == $past(exp_a))
        else $error("window a level wrong");
    win_b_level_a:
        assert property (win_out.win_b == $past(exp_b))
        else $error("window b level wrong");
endmodule

bind msnp_core msnp_core_sva u_msnp_sva (
    .clk(clk), .reset_n(reset_n), .param(param), .move_start(move_start),
    .move_active(move_active), .present_pos(present_pos), .cmd_speed(cmd_speed),
    .stage(stage), .win_out(win_out), .window_output_polarity(window_output_polarity)
);

//--- msnp_servo_model.sv
// Behavioural servo position loop: announces a move, then walks the position.
// Assumes the bench pulses go for one cycle while no move is running.
`timescale 1ns/1ps
module msnp_servo_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [31:0] home,
    input  wire logic [31:0] rate,
    input  wire logic [7:0]  len,
    output logic             move_start,
    output logic             move_active,
    output logic [31:0]      present_pos
);
    logic [7:0] left = 8'h00;
    initial begin
        move_start = 1'b0;
        move_active = 1'b0;
        present_pos = 32'h0000_0000;
    end
    // Start pulse, then rate steps per cycle; small rate gives a slow axis
    always @(posedge clk) begin
        move_start <= go;
        if (go) begin
            present_pos <= home;
            move_active <= 1'b1;
            left <= len;
        end else if (left != 8'h00) begin
            present_pos <= present_pos + rate;
            left <= left - 8'h01;
        end else begin
            move_active <= 1'b0;
        end
    end
endmodule

//--- multispeed_notch_positioning_tb_top.sv
// Self-checking bench for msnp_core driven by a behavioural servo loop.
// Assumes inputs change at the falling edge; the checker is bound in.
`timescale 1ns/1ps
module multispeed_notch_positioning_tb_top;
    logic                  clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  go = 1'b0;
    logic                  mon = 1'b0;
    logic [1:0]            pol = 2'b00;
    msnp_pkg::msnp_param_t param = '0;
    msnp_pkg::msnp_win_t   win_out;
    logic                  move_start, move_active;
    logic [31:0]           present_pos;
    logic [15:0]           cmd_speed, window_output_polarity;
    logic [4:0]            stage, last = 5'h00;
    int                    n_mismatch = 0, check_count = 0, na, nb;

    always #2.5 clk = ~clk;

    msnp_servo_model u_servo (.clk(clk), .go(go), .home(32'h0000_03e8), .rate(32'h0000_0001),
        .len(8'h3c), .move_start(move_start), .move_active(move_active), .present_pos(present_pos));
    msnp_core DUT (.clk(clk), .reset_n(reset_n), .param(param), .move_start(move_start),
        .move_active(move_active), .present_pos(present_pos), .cmd_speed(cmd_speed),
        .stage(stage), .win_out(win_out), .window_output_polarity(window_output_polarity));

    // ----
    // Tasks
    // ----
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] attr, input logic [31:0] data);
        @(negedge clk);
        param = '{1'b1, attr, data};
        @(negedge clk);
        param.wr = 1'b0;
    endtask
    // One move from step 1000 over 60 steps; ea/eb are expected cycles off rest
    task automatic run(input int ea, input int eb);
        na = 0;
        nb = 0;
        mon = 1'b1;
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        @(negedge clk);
        check("initial speed", 32'(cmd_speed), 32'h5);
        for (int i = 0; i < 200 && move_active === 1'b1; i++) @(negedge clk);
        check("move ended", 32'(move_active), 32'h0);
        check("final stage", 32'(stage), 32'h3);
        check("final speed", 32'(cmd_speed), 32'h13);
        repeat (3) @(negedge clk);
        mon = 1'b0;
        check("idle speed", 32'(cmd_speed), 32'h0);
        check("window a cycles", 32'(na), 32'(ea));
        check("window b cycles", 32'(nb), 32'(eb));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Window cycles counted and every stage step audited on settled values
    always @(negedge clk) begin
        if (mon) begin
            if (win_out.win_a !== pol[0]) na++;
            if (win_out.win_b !== pol[1]) nb++;
            if (stage !== last && stage !== 5'h00) begin
                check("stage speed", 32'(cmd_speed), 32'h10 + 32'(stage));
                check("stage travel", 32'(present_pos - 32'h3e8 - 32'h0a * stage <= 32'h3), 1);
            end
            last = stage;
        end
    end

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        check("reset speed", 32'(cmd_speed), 32'h0);
        check("reset windows", 32'(win_out), 32'h0);
        wr(msnp_pkg::ATTR_WIN_POL, 32'h0000_0002);
        pol = 2'b10;
        wr(8'h50, 32'h0000_ffff);
        @(negedge clk);
        check("polarity readback", 32'(window_output_polarity), 32'h2);
        check("resting windows", 32'(win_out), 32'h1);
        for (int k = 0; k < 16; k++) begin
            wr(msnp_pkg::ATTR_POS_FIRST + 8'(k), 32'(10 * (k + 1)));
            wr(msnp_pkg::ATTR_SPD_FIRST + 8'(k), 32'(17 + k));
        end
        wr(msnp_pkg::ATTR_STAGE_COUNT, 32'h0000_0003);
        wr(msnp_pkg::ATTR_INIT_SPEED, 32'h0000_0005);
        wr(msnp_pkg::ATTR_WIN_A_LO, 32'h0000_03f2);
        wr(msnp_pkg::ATTR_WIN_A_HI, 32'h0000_03fc);
        wr(msnp_pkg::ATTR_WIN_B_LO, 32'h0000_0014);
        wr(msnp_pkg::ATTR_WIN_B_HI, 32'h0000_0019);
        run(11, 0);
        wr(msnp_pkg::ATTR_WIN_REF, 32'h0000_0001);
        run(0, 6);
        // Swapped polarities, back to absolute limits
        wr(msnp_pkg::ATTR_WIN_POL, 32'h0000_0001);
        pol = 2'b01;
        wr(msnp_pkg::ATTR_WIN_REF, 32'h0000_0000);
        @(negedge clk);
        check("swapped rest", 32'(win_out), 32'h2);
        run(11, 0);
        print_verdict();
    end

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
endmodule
